// *** core/timer8_pkg.sv ***
package timer8_pkg;
	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_COUNT  = 8'h04;
	localparam logic [7:0] OFS_CMP    = 8'h08;
	localparam logic [7:0] OFS_FLAGS  = 8'h0C;
	localparam logic [7:0] OFS_IRQEN  = 8'h10;
	localparam logic [7:0] OFS_PORT   = 8'h14;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_MODE_LSB   = 0;
	localparam int CTRL_ACTION_LSB = 4;
	localparam int CTRL_FORCE_BIT  = 7;
	localparam int CTRL_CLKSEL_LSB = 8;
	localparam int FLAG_OVF_BIT    = 0;
	localparam int FLAG_CMP_BIT    = 1;
	localparam int PORT_VALUE_BIT  = 0;
	localparam int PORT_DIR_BIT    = 1;

	// ----------------------------------------------------------------
	// values
	// ----------------------------------------------------------------
	localparam logic [7:0]  COUNT_MAX    = 8'hFF;
	localparam logic [7:0]  COUNT_BOTTOM = 8'h00;
	localparam logic [7:0]  RESET_BYTE   = 8'h00;
	localparam logic [2:0]  CLKSEL_OFF   = 3'h0;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;
	localparam logic [31:0] READ_ZERO    = 32'h0000_0000;

	typedef enum logic [1:0] {
		MODE_NORMAL = 2'h0,
		MODE_PHASE  = 2'h1,
		MODE_CTC    = 2'h2,
		MODE_FAST   = 2'h3
	} wave_mode_t;

	typedef enum logic [1:0] {
		ACT_NONE   = 2'h0,
		ACT_TOGGLE = 2'h1,
		ACT_CLEAR  = 2'h2,
		ACT_SET    = 2'h3
	} out_action_t;

	// prescale taps: tick when the low bits of the divider are all ones
	localparam logic [9:0] TAP_DIV8    = 10'h007;
	localparam logic [9:0] TAP_DIV32   = 10'h01F;
	localparam logic [9:0] TAP_DIV64   = 10'h03F;
	localparam logic [9:0] TAP_DIV128  = 10'h07F;
	localparam logic [9:0] TAP_DIV256  = 10'h0FF;
	localparam logic [9:0] TAP_DIV1024 = 10'h3FF;
endpackage

// *** core/tick_divider.sv ***
module tick_divider
(
	input  wire logic       CLK,         // system clock
	input  wire logic       RSTN,        // synchronous reset, active low
	input  wire logic [2:0] clk_select,  // clock source select
	output logic            timer_tick   // one-cycle count enable
);
	logic [9:0] div_reg;
	logic [9:0] tap;

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
			div_reg <= 10'h000;
		else
			div_reg <= div_reg + 10'h001;
	end

	always_comb
	begin
		case (clk_select)
			3'h2:    tap = timer8_pkg::TAP_DIV8;
			3'h3:    tap = timer8_pkg::TAP_DIV32;
			3'h4:    tap = timer8_pkg::TAP_DIV64;
			3'h5:    tap = timer8_pkg::TAP_DIV128;
			3'h6:    tap = timer8_pkg::TAP_DIV256;
			default: tap = timer8_pkg::TAP_DIV1024;
		endcase
	end

	// selecting zero stops the ticks entirely
	always_comb
	begin
		if (clk_select == timer8_pkg::CLKSEL_OFF)
			timer_tick = 1'b0;
		else if (clk_select == 3'h1)
			timer_tick = 1'b1;
		else
			timer_tick = ((div_reg & tap) == tap);
	end
endmodule // tick_divider

// *** core/count_core.sv ***
module count_core
(
	input  wire logic       CLK,        // system clock
	input  wire logic       RSTN,       // synchronous reset, active low
	input  wire logic       tick,       // count enable
	input  wire logic [1:0] mode,       // waveform mode select
	input  wire logic       clear,      // clear on compare
	input  wire logic       wr_en,      // cpu write strobe
	input  wire logic [7:0] wr_data,    // cpu write value
	output logic [7:0]      count,      // counter value
	output logic            count_up,   // current direction
	output logic            at_top,     // counter holds max
	output logic            at_bottom   // counter holds zero
);
	logic [7:0] count_next;
	logic       up_next;

	assign at_top    = (count == timer8_pkg::COUNT_MAX);
	assign at_bottom = (count == timer8_pkg::COUNT_BOTTOM);

	always_comb
	begin
		count_next = count;
		up_next    = count_up;
		if (wr_en)
			count_next = wr_data;
		else if (tick)
		begin
			case (mode)
				timer8_pkg::MODE_PHASE:
				begin
					if (at_top)
						up_next = 1'b0;
					else if (at_bottom)
						up_next = 1'b1;
					if ((at_top || !count_up) && !at_bottom)
						count_next = count - 8'h01;
					else
						count_next = count + 8'h01;
				end
				timer8_pkg::MODE_CTC:
					count_next = clear ? 8'h00 : count + 8'h01;
				default:
					count_next = count + 8'h01;
			endcase
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			count    <= 8'h00;
			count_up <= 1'b1;
		end
		else
		begin
			count    <= count_next;
			count_up <= up_next;
		end
	end
endmodule // count_core

// *** core/timer8_counter_compare_unit.sv ***
//
// Contract
// - each tick clears, increments or decrements counter
// - clock select zero halts the counter
// - cpu reads and writes counter any time
// - cpu counter write beats clear or count
// - mode bits choose sequence and overflow point
// - equality sets compare flag on next tick
// - enabled compare flag requests irq, service clears
// - writing one clears compare flag
// - compare double buffered only in pwm modes
// - cpu reaches buffer or active compare
// - force strobe drives output like a match, sets no flag, non-pwm only
// - counter write blocks match on next tick
// - compare output kept across mode changes
// - output action change applies next match
// - nonzero action overrides port value on pin
// - zero action leaves compare output alone
// - normal mode counts up, wraps to zero
// - normal overflow flag set when reaching zero
// - servicing overflow irq clears its flag
// - top and bottom indications from counter
// - mode two clears counter on compare
// - mode three is fast pwm zero to max
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
module timer8_counter_compare_unit
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic              CLK,      // system clock, 25 MHz
	input  wire logic              RSTN,     // synchronous reset, low
	input  wire logic [ADDR_W-1:0] AWADDR,   // write address
	input  wire logic              AWVALID,  // write address valid
	output logic                   AWREADY,  // write address ready
	input  wire logic [31:0]       WDATA,    // write data
	input  wire logic [3:0]        WSTRB,    // write byte enables
	input  wire logic              WVALID,   // write data valid
	output logic                   WREADY,   // write data ready
	output logic [1:0]             BRESP,    // write response
	output logic                   BVALID,   // write response valid
	input  wire logic              BREADY,   // write response ready
	input  wire logic [ADDR_W-1:0] ARADDR,   // read address
	input  wire logic              ARVALID,  // read address valid
	output logic                   ARREADY,  // read address ready
	output logic [31:0]            RDATA,    // read data
	output logic [1:0]             RRESP,    // read response
	output logic                   RVALID,   // read data valid
	input  wire logic              RREADY,   // read data ready
	input  wire logic              OVF_ACK,  // overflow irq serviced
	input  wire logic              CMP_ACK,  // compare irq serviced
	output logic                   OVF_IRQ,  // overflow irq request
	output logic                   CMP_IRQ,  // compare irq request
	output logic                   PIN_O,    // compare pin level
	output logic                   PIN_OE    // compare pin drive enable
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	logic [1:0]        mode_reg;
	logic [1:0]        action_reg;
	logic [2:0]        clksel_reg;
	logic [7:0]        cmp_active_reg;
	logic [7:0]        cmp_buf_reg;
	logic              ovf_flag_reg;
	logic              cmp_flag_reg;
	logic              ovf_en_reg;
	logic              cmp_en_reg;
	logic              port_val_reg;
	logic              pin_dir_reg;
	logic              oc_reg;
	logic              block_reg;
	logic              aw_have_reg;
	logic              w_have_reg;
	logic [ADDR_W-1:0] awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;

	logic              ovf_flag_next;
	logic              cmp_flag_next;
	logic              oc_next;
	logic              tick;
	logic [7:0]        count;
	logic              count_up;
	logic              at_top;
	logic              at_bottom;

	// ----------------------------------------------------------------
	// write decode
	// ----------------------------------------------------------------
	logic wr_fire;
	logic wr_ctrl;
	logic wr_count;
	logic wr_cmp;
	logic wr_flags;
	logic wr_irqen;
	logic wr_port;
	logic wr_hit;
	logic lane0;
	logic lane1;

	assign wr_fire = aw_have_reg && w_have_reg && !BVALID;
	assign lane0   = wstrb_reg[0];
	assign lane1   = wstrb_reg[1];

	always_comb
	begin
		wr_ctrl  = 1'b0;
		wr_count = 1'b0;
		wr_cmp   = 1'b0;
		wr_flags = 1'b0;
		wr_irqen = 1'b0;
		wr_port  = 1'b0;
		wr_hit   = 1'b1;
		if (awaddr_reg[7:0] == timer8_pkg::OFS_CTRL)
			wr_ctrl = wr_fire;
		else if (awaddr_reg[7:0] == timer8_pkg::OFS_COUNT)
			wr_count = wr_fire && lane0;
		else if (awaddr_reg[7:0] == timer8_pkg::OFS_CMP)
			wr_cmp = wr_fire && lane0;
		else if (awaddr_reg[7:0] == timer8_pkg::OFS_FLAGS)
			wr_flags = wr_fire && lane0;
		else if (awaddr_reg[7:0] == timer8_pkg::OFS_IRQEN)
			wr_irqen = wr_fire && lane0;
		else if (awaddr_reg[7:0] == timer8_pkg::OFS_PORT)
			wr_port = wr_fire && lane0;
		else
			wr_hit = 1'b0;
	end

	// ----------------------------------------------------------------
	// write channels: address and data taken in either order
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg  <= 1'b0;
			AWREADY     <= 1'b1;
			WREADY      <= 1'b1;
			BVALID      <= 1'b0;
			BRESP       <= timer8_pkg::RESP_OKAY;
			awaddr_reg  <= '0;
			wdata_reg   <= 32'h0000_0000;
			wstrb_reg   <= 4'h0;
		end
		else
		begin
			if (AWVALID && AWREADY)
			begin
				aw_have_reg <= 1'b1;
				AWREADY     <= 1'b0;
				awaddr_reg  <= AWADDR;
			end
			if (WVALID && WREADY)
			begin
				w_have_reg <= 1'b1;
				WREADY     <= 1'b0;
				wdata_reg  <= WDATA;
				wstrb_reg  <= WSTRB;
			end
			if (wr_fire)
			begin
				BVALID <= 1'b1;
				BRESP  <= wr_hit ? timer8_pkg::RESP_OKAY
				                 : timer8_pkg::RESP_SLVERR;
			end
			if (BVALID && BREADY)
			begin
				BVALID      <= 1'b0;
				aw_have_reg <= 1'b0;
				w_have_reg  <= 1'b0;
				AWREADY     <= 1'b1;
				WREADY      <= 1'b1;
			end
		end
	end

	// ----------------------------------------------------------------
	// tick source and counter
	// ----------------------------------------------------------------
	tick_divider u_div
	(
		.CLK        (CLK),
		.RSTN       (RSTN),
		.clk_select (clksel_reg),
		.timer_tick (tick)
	);

	logic pwm_mode;
	logic match;
	logic match_evt;
	logic force_evt;
	logic ovf_evt;

	assign pwm_mode = (mode_reg == timer8_pkg::MODE_PHASE) ||
	                  (mode_reg == timer8_pkg::MODE_FAST);
	assign match    = (count == cmp_active_reg);
	assign match_evt = tick && match && !block_reg && !wr_count;
	assign force_evt = wr_ctrl && lane0 && !pwm_mode &&
	                   wdata_reg[timer8_pkg::CTRL_FORCE_BIT];

	// a control write that also strobes force acts with its own action bits
	logic [1:0] act_now;
	assign act_now = (wr_ctrl && lane0)
	               ? wdata_reg[timer8_pkg::CTRL_ACTION_LSB +: 2]
	               : action_reg;

	count_core u_cnt
	(
		.CLK       (CLK),
		.RSTN      (RSTN),
		.tick      (tick),
		.mode      (mode_reg),
		.clear     (match && !block_reg),
		.wr_en     (wr_count),
		.wr_data   (wdata_reg[7:0]),
		.count     (count),
		.count_up  (count_up),
		.at_top    (at_top),
		.at_bottom (at_bottom)
	);

	// overflow point depends on the count sequence
	always_comb
	begin
		case (mode_reg)
			timer8_pkg::MODE_PHASE:
				ovf_evt = !count_up && !at_top &&
				          (count == 8'h01);
			timer8_pkg::MODE_FAST:
				ovf_evt = (count == timer8_pkg::COUNT_MAX - 8'h01);
			default:
				ovf_evt = at_top;
		endcase
		ovf_evt = ovf_evt && tick && !wr_count;
	end

	// block one match after any counter write, even when stopped
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
			block_reg <= 1'b0;
		else if (wr_count)
			block_reg <= 1'b1;
		else if (tick)
			block_reg <= 1'b0;
	end

	// ----------------------------------------------------------------
	// control, enables and port registers
	// ----------------------------------------------------------------
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			mode_reg     <= timer8_pkg::MODE_NORMAL;
			action_reg   <= timer8_pkg::ACT_NONE;
			clksel_reg   <= timer8_pkg::CLKSEL_OFF;
			ovf_en_reg   <= 1'b0;
			cmp_en_reg   <= 1'b0;
			port_val_reg <= 1'b0;
			pin_dir_reg  <= 1'b0;
		end
		else
		begin
			if (wr_ctrl && lane0)
			begin
				mode_reg   <= wdata_reg[timer8_pkg::CTRL_MODE_LSB +: 2];
				action_reg <= wdata_reg[timer8_pkg::CTRL_ACTION_LSB +: 2];
			end
			if (wr_ctrl && lane1)
				clksel_reg <= wdata_reg[timer8_pkg::CTRL_CLKSEL_LSB +: 3];
			if (wr_irqen)
			begin
				ovf_en_reg <= wdata_reg[timer8_pkg::FLAG_OVF_BIT];
				cmp_en_reg <= wdata_reg[timer8_pkg::FLAG_CMP_BIT];
			end
			if (wr_port)
			begin
				port_val_reg <= wdata_reg[timer8_pkg::PORT_VALUE_BIT];
				pin_dir_reg  <= wdata_reg[timer8_pkg::PORT_DIR_BIT];
			end
		end
	end

	// ----------------------------------------------------------------
	// compare value with buffer
	// ----------------------------------------------------------------
	// the pwm update at max keeps every period a whole length
	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			cmp_active_reg <= timer8_pkg::RESET_BYTE;
			cmp_buf_reg    <= timer8_pkg::RESET_BYTE;
		end
		else
		begin
			if (wr_cmp)
				cmp_buf_reg <= wdata_reg[7:0];
			if (wr_cmp && !pwm_mode)
				cmp_active_reg <= wdata_reg[7:0];
			else if (pwm_mode && tick && at_top && !wr_count)
				cmp_active_reg <= cmp_buf_reg;
		end
	end

	// ----------------------------------------------------------------
	// flags: hardware set wins over any clear in the same cycle
	// ----------------------------------------------------------------
	always_comb
	begin
		ovf_flag_next = ovf_flag_reg;
		cmp_flag_next = cmp_flag_reg;
		if (wr_flags && wdata_reg[timer8_pkg::FLAG_OVF_BIT])
			ovf_flag_next = 1'b0;
		if (wr_flags && wdata_reg[timer8_pkg::FLAG_CMP_BIT])
			cmp_flag_next = 1'b0;
		if (OVF_ACK)
			ovf_flag_next = 1'b0;
		if (CMP_ACK)
			cmp_flag_next = 1'b0;
		if (ovf_evt)
			ovf_flag_next = 1'b1;
		if (match_evt)
			cmp_flag_next = 1'b1;
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			ovf_flag_reg <= 1'b0;
			cmp_flag_reg <= 1'b0;
			OVF_IRQ      <= 1'b0;
			CMP_IRQ      <= 1'b0;
		end
		else
		begin
			ovf_flag_reg <= ovf_flag_next;
			cmp_flag_reg <= cmp_flag_next;
			OVF_IRQ      <= ovf_flag_next && ovf_en_reg;
			CMP_IRQ      <= cmp_flag_next && cmp_en_reg;
		end
	end

	// ----------------------------------------------------------------
	// compare output and pin
	// ----------------------------------------------------------------
	// the live action field is used, so a new setting rules the next match
	always_comb
	begin
		oc_next = oc_reg;
		if (act_now != timer8_pkg::ACT_NONE)
		begin
			if (force_evt || (match_evt && !pwm_mode))
			begin
				case (act_now)
					timer8_pkg::ACT_TOGGLE: oc_next = !oc_reg;
					timer8_pkg::ACT_CLEAR:  oc_next = 1'b0;
					default:                oc_next = 1'b1;
				endcase
			end
			else if (match_evt)
			begin
				if (act_now == timer8_pkg::ACT_TOGGLE)
					oc_next = !oc_reg;
				else if (mode_reg == timer8_pkg::MODE_FAST)
					oc_next = (act_now == timer8_pkg::ACT_SET);
				else
					oc_next = (act_now == timer8_pkg::ACT_SET) ==
					          count_up;
			end
			else if (tick && at_top && !wr_count &&
			         mode_reg == timer8_pkg::MODE_FAST &&
			         act_now != timer8_pkg::ACT_TOGGLE)
				oc_next = (act_now == timer8_pkg::ACT_CLEAR);
		end
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			oc_reg <= 1'b0;
			PIN_O  <= 1'b0;
			PIN_OE <= 1'b0;
		end
		else
		begin
			oc_reg <= oc_next;
			PIN_O  <= (act_now != timer8_pkg::ACT_NONE) ? oc_next
			                                            : port_val_reg;
			PIN_OE <= pin_dir_reg;
		end
	end

	// ----------------------------------------------------------------
	// read channel
	// ----------------------------------------------------------------
	logic [31:0] rd_word;
	logic        rd_hit;

	always_comb
	begin
		rd_word = timer8_pkg::READ_ZERO;
		rd_hit  = 1'b1;
		if (ARADDR[7:0] == timer8_pkg::OFS_CTRL)
		begin
			rd_word[timer8_pkg::CTRL_MODE_LSB +: 2]   = mode_reg;
			rd_word[timer8_pkg::CTRL_ACTION_LSB +: 2] = action_reg;
			rd_word[timer8_pkg::CTRL_CLKSEL_LSB +: 3] = clksel_reg;
		end
		else if (ARADDR[7:0] == timer8_pkg::OFS_COUNT)
			rd_word[7:0] = count;
		else if (ARADDR[7:0] == timer8_pkg::OFS_CMP)
			rd_word[7:0] = pwm_mode ? cmp_buf_reg : cmp_active_reg;
		else if (ARADDR[7:0] == timer8_pkg::OFS_FLAGS)
		begin
			rd_word[timer8_pkg::FLAG_OVF_BIT] = ovf_flag_reg;
			rd_word[timer8_pkg::FLAG_CMP_BIT] = cmp_flag_reg;
		end
		else if (ARADDR[7:0] == timer8_pkg::OFS_IRQEN)
		begin
			rd_word[timer8_pkg::FLAG_OVF_BIT] = ovf_en_reg;
			rd_word[timer8_pkg::FLAG_CMP_BIT] = cmp_en_reg;
		end
		else if (ARADDR[7:0] == timer8_pkg::OFS_PORT)
		begin
			rd_word[timer8_pkg::PORT_VALUE_BIT] = port_val_reg;
			rd_word[timer8_pkg::PORT_DIR_BIT]   = pin_dir_reg;
		end
		else
			rd_hit = 1'b0;
	end

	always_ff @(posedge CLK)
	begin
		if (!RSTN)
		begin
			ARREADY <= 1'b1;
			RVALID  <= 1'b0;
			RDATA   <= timer8_pkg::READ_ZERO;
			RRESP   <= timer8_pkg::RESP_OKAY;
		end
		else if (ARVALID && ARREADY)
		begin
			ARREADY <= 1'b0;
			RVALID  <= 1'b1;
			RDATA   <= rd_word;
			RRESP   <= rd_hit ? timer8_pkg::RESP_OKAY
			                  : timer8_pkg::RESP_SLVERR;
		end
		else if (RVALID && RREADY)
		begin
			RVALID  <= 1'b0;
			ARREADY <= 1'b1;
		end
	end
endmodule // timer8_counter_compare_unit

// *** sim/timer8_monitor.sv ***
module timer8_monitor
(
	input wire logic        CLK,     // clock
	input wire logic        RSTN,    // reset
	input wire logic        AWVALID, // aw valid
	input wire logic        AWREADY, // aw ready
	input wire logic        WVALID,  // w valid
	input wire logic        WREADY,  // w ready
	input wire logic        BVALID,  // b valid
	input wire logic        BREADY,  // b ready
	input wire logic [1:0]  BRESP,   // b resp
	input wire logic        ARVALID, // ar valid
	input wire logic        ARREADY, // ar ready
	input wire logic        RVALID,  // r valid
	input wire logic        RREADY,  // r ready
	input wire logic        OVF_ACK, // ovf ack
	input wire logic        OVF_IRQ, // ovf irq
	input wire logic        CMP_IRQ, // cmp irq
	input wire logic        PIN_O,   // pin level
	input wire logic        PIN_OE   // pin enable
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);

	// ------------------------------------------------------------
	// bus and timer checks
	// ------------------------------------------------------------
	b_once_a: assert property (BVALID && BREADY |=> !BVALID)
		else $error("write response repeated");
	r_once_a: assert property (RVALID && RREADY |=> !RVALID)
		else $error("read data repeated");
	wr_block_a: assert property (BVALID |-> !AWREADY && !WREADY)
		else $error("write accepted during response");
	rd_block_a: assert property (RVALID |-> !ARREADY)
		else $error("read accepted during data");
	rd_answer_a: assert property (ARVALID && ARREADY |=> RVALID)
		else $error("read not answered");
	wr_answer_a: assert property
		(AWVALID && AWREADY && WVALID && WREADY |-> ##[1:3] BVALID)
		else $error("write not answered");
	reset_clear_a: assert property (disable iff (1'b0) !RSTN |=>
		!BVALID && !RVALID && !OVF_IRQ && !CMP_IRQ && !PIN_O && !PIN_OE)
		else $error("outputs not cleared by reset");
	// no write and no service: counting alone must keep the flag
	irq_hold_a: assert property (OVF_IRQ && !OVF_ACK &&
		AWREADY && !AWVALID |=> OVF_IRQ)
		else $error("overflow request lost");
	pin_dir_a: assert property ($changed(PIN_OE) |-> $past(BVALID))
		else $error("pin direction moved without write");

	cover property (OVF_IRQ);
	cover property (CMP_IRQ);
	cover property ($rose(PIN_O));
	cover property (BVALID && BRESP == 2'h2);
endmodule // timer8_monitor

// *** sim/pin_model.sv ***
module pin_model
(
	input  wire logic drv_o,  // level from unit
	input  wire logic drv_oe, // drive enable
	output logic      pad     // resolved pad
);
	timeunit 1ns;
	timeprecision 1ns;
	// pull-down: an undriven pad reads low, never a stale level
	assign pad = drv_oe ? drv_o : 1'b0;
endmodule // pin_model

// *** sim/timer8_counter_compare_unit_test.sv ***
`define CHK(nm, e, g) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			n_errors++; \
			$display("unexpected %s exp %h got %h", nm, e, g); \
		end \
	end
module timer8_counter_compare_unit_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic        clk, rstn, awvalid, wvalid, bready, arvalid, rready;
	logic        ovf_ack, cmp_ack;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rd;
	logic [3:0]  wstrb;
	logic [1:0]  rs;
	wire logic   awready, wready, bvalid, arready, rvalid, pad;
	wire logic   ovf_irq, cmp_irq, pin_o, pin_oe;
	wire logic [1:0]  bresp, rresp;
	wire logic [31:0] rdata;
	int          n_errors, tests_run, cyc;

	timer8_counter_compare_unit #(.ADDR_W(8)) dut_u (.CLK(clk),
		.RSTN(rstn), .AWADDR(awaddr), .AWVALID(awvalid),
		.AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb),
		.WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
		.BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
		.ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata),
		.RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
		.OVF_ACK(ovf_ack), .CMP_ACK(cmp_ack), .OVF_IRQ(ovf_irq),
		.CMP_IRQ(cmp_irq), .PIN_O(pin_o), .PIN_OE(pin_oe));
	pin_model pin_u (.drv_o(pin_o), .drv_oe(pin_oe), .pad(pad));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ------------------------------------------------------------
	// bus tasks
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw && w))
		begin
			@(posedge clk);
			aw = aw | awready;
			w = w | wready;
			if (aw) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		do @(posedge clk); while (!bvalid);
		rs = bresp;
		// one more edge so outputs launched by the write have settled
		@(posedge clk);
	endtask

	task automatic rd_reg(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk); while (!rvalid);
		rd = rdata;
		rs = rresp;
	endtask

	task automatic exp_rd(input logic [7:0] a, input logic [31:0] e);
		rd_reg(a);
		`CHK("read word", e, rd)
	endtask

	task automatic pulse(input bit ovf);
		if (ovf) ovf_ack <= 1'b1;
		else cmp_ack <= 1'b1;
		@(posedge clk);
		ovf_ack <= 1'b0;
		cmp_ack <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// cut a hang short; the whole sequence needs well under this
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial
	begin
		{rstn, awvalid, wvalid, arvalid, ovf_ack, cmp_ack} = 6'h00;
		{bready, rready} = 2'h3;
		{awaddr, araddr, wdata, wstrb} = 52'h0_0000_0000_000F;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 6; i++)
			exp_rd(8'(4 * i), 32'h0);
		`CHK("pin", 2'h0, {pin_o, pin_oe})
		$display("test reset done");

		wr(timer8_pkg::OFS_COUNT, 32'h5A);
		repeat (20) @(posedge clk);
		exp_rd(timer8_pkg::OFS_COUNT, 32'h5A);
		wr(8'h18, 32'h1);
		`CHK("bresp", timer8_pkg::RESP_SLVERR, rs)
		rd_reg(8'h18);
		`CHK("rresp", timer8_pkg::RESP_SLVERR, rs)
		$display("test access done");

		wr(timer8_pkg::OFS_COUNT, 32'hFD);
		wr(timer8_pkg::OFS_CTRL, 32'h100);
		repeat (6) @(posedge clk);
		wr(timer8_pkg::OFS_CTRL, 32'h0);
		rd_reg(timer8_pkg::OFS_COUNT);
		`CHK("wrapped", 1'b1, rd < 32'h10)
		exp_rd(timer8_pkg::OFS_FLAGS, 32'h3);
		wr(timer8_pkg::OFS_IRQEN, 32'h1);
		`CHK("ovf irq", 1'b1, ovf_irq)
		pulse(1'b1);
		`CHK("ovf irq", 1'b0, ovf_irq)
		wr(timer8_pkg::OFS_IRQEN, 32'h2);
		`CHK("cmp irq", 1'b1, cmp_irq)
		wr(timer8_pkg::OFS_FLAGS, 32'h0);
		exp_rd(timer8_pkg::OFS_FLAGS, 32'h2);
		wr(timer8_pkg::OFS_FLAGS, 32'h2);
		`CHK("cmp irq", 1'b0, cmp_irq)
		$display("test flags done");

		wr(timer8_pkg::OFS_CMP, 32'h5);
		wr(timer8_pkg::OFS_COUNT, 32'h5);
		wr(timer8_pkg::OFS_CTRL, 32'h100);
		wr(timer8_pkg::OFS_CTRL, 32'h0);
		exp_rd(timer8_pkg::OFS_FLAGS, 32'h0);
		$display("test blocking done");

		wr(timer8_pkg::OFS_CMP, 32'h3);
		wr(timer8_pkg::OFS_COUNT, 32'h0);
		wr(timer8_pkg::OFS_CTRL, 32'h102);
		repeat (6)
		begin
			rd_reg(timer8_pkg::OFS_COUNT);
			`CHK("ctc count", 1'b1, rd <= 32'h3)
		end
		wr(timer8_pkg::OFS_CTRL, 32'h2);
		exp_rd(timer8_pkg::OFS_FLAGS, 32'h2);
		pulse(1'b0);
		`CHK("cmp irq", 1'b0, cmp_irq)
		$display("test ctc done");

		// output state is set before the pin is turned to output
		wr(timer8_pkg::OFS_CTRL, 32'hB0);
		wr(timer8_pkg::OFS_PORT, 32'h2);
		`CHK("pad set", 1'b1, pad)
		wr(timer8_pkg::OFS_CTRL, 32'hA0);
		`CHK("pad clear", 1'b0, pad)
		wr(timer8_pkg::OFS_CTRL, 32'h90);
		`CHK("pad toggle", 1'b1, pad)
		wr(timer8_pkg::OFS_CTRL, 32'h03);
		`CHK("port value", 1'b0, pad)
		wr(timer8_pkg::OFS_CMP, 32'h40);
		exp_rd(timer8_pkg::OFS_CMP, 32'h40);
		wr(timer8_pkg::OFS_CTRL, 32'h10);
		`CHK("kept output", 1'b1, pad)
		exp_rd(timer8_pkg::OFS_FLAGS, 32'h0);
		exp_rd(timer8_pkg::OFS_CMP, 32'h3);
		$display("test output done");

		wr(timer8_pkg::OFS_CTRL, 32'h03);
		wr(timer8_pkg::OFS_COUNT, 32'hF0);
		wr(timer8_pkg::OFS_CTRL, 32'h103);
		repeat (30) @(posedge clk);
		wr(timer8_pkg::OFS_CTRL, 32'h03);
		rd_reg(timer8_pkg::OFS_COUNT);
		`CHK("fast wrapped", 1'b1, rd < 32'h40)
		exp_rd(timer8_pkg::OFS_FLAGS, 32'h1);
		wr(timer8_pkg::OFS_CTRL, 32'h0);
		exp_rd(timer8_pkg::OFS_CMP, 32'h40);
		$display("test fast done");
		give_verdict();
	end
endmodule // timer8_counter_compare_unit_test

bind timer8_counter_compare_unit timer8_monitor mon_u (.CLK(CLK),
	.RSTN(RSTN), .AWVALID(AWVALID), .AWREADY(AWREADY),
	.WVALID(WVALID), .WREADY(WREADY), .BVALID(BVALID),
	.BREADY(BREADY), .BRESP(BRESP), .ARVALID(ARVALID),
	.ARREADY(ARREADY), .RVALID(RVALID), .RREADY(RREADY),
	.OVF_ACK(OVF_ACK), .OVF_IRQ(OVF_IRQ), .CMP_IRQ(CMP_IRQ),
	.PIN_O(PIN_O), .PIN_OE(PIN_OE));
